// ===== common/tcc_defs.svh
// register offsets, field positions, reset values and counter limits for the timer capture/compare block
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register byte addresses (word aligned)
`define TCC_OFF_SECONDARY   16'hff14
`define TCC_OFF_PRIMARY     16'hff18
`define TCC_OFF_COUNTER     16'hff1c
`define TCC_OFF_MODE        16'hff20
`define TCC_OFF_CAPCTL      16'hff24
`define TCC_OFF_OUTCTL      16'hff28
`define TCC_OFF_PRESCALE    16'hff2c
`define TCC_OFF_STATUS      16'hff30
`define TCC_OFF_MASK        16'hff34

// reset values
`define TCC_RST_CC          16'h0000
`define TCC_RST_MASK        4'hf

// mode control fields
`define TCC_MODE_LSB        0
`define TCC_MODE_W          2

// capture/compare control fields
`define TCC_CAP_PRI_BIT     0
`define TCC_CAP_SEC_BIT     1

// output control fields
`define TCC_OUT_EN_BIT      0

// prescaler: trigger edge selects, 2 bits each (00 fall, 01 rise, 1x both)
`define TCC_EDGE_FIRST_LSB  4
`define TCC_EDGE_SECOND_LSB 6

// status / mask bit positions
`define TCC_ST_SEC_MATCH    0
`define TCC_ST_PRI_MATCH    1
`define TCC_ST_OVERFLOW     2
`define TCC_ST_CAPTURE      3
`define TCC_ST_W            4

// counter limits
`define TCC_COUNT_ZERO      16'h0000
`define TCC_COUNT_ONE       16'h0001
`define TCC_COUNT_MAX       16'hffff

`endif

// ===== common/tcc_pkg.sv
// types shared by the timer capture/compare block
package tcc_pkg;

	// operating mode held in the mode control register
	typedef enum logic [1:0]
	{
		TCC_STOP,
		TCC_CLEAR_ON_EDGE,
		TCC_FREE_RUN,
		TCC_CLEAR_ON_MATCH
	} tcc_mode_t;

	// avalon-mm request from the master
	typedef struct packed
	{
		logic        read;
		logic        write;
		logic [15:0] address;
		logic [31:0] writedata;
	} tcc_req_t;

	// avalon-mm answer to the master
	typedef struct packed
	{
		logic        waitrequest;
		logic [31:0] readdata;
	} tcc_rsp_t;

	// conditioned pin events for one cycle
	typedef struct packed
	{
		logic first;
		logic second;
	} tcc_edges_t;

endpackage

// ===== rtl/tcc_edge_detect.sv
// selectable-polarity edge detector for the capture trigger pins
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_edge_detect
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       clkEn,
	// pin and edge select
	input  wire logic       pinIn,
	input  wire logic [1:0] edgeSel,
	// detected valid edge, one cycle
	output logic            validEdge
);

	logic pinPrev_q;   // pin level one cycle ago

	////////////////////////////////////////////////////////////////////////
	// remember previous pin level
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pinPrev_q <= 1'b0;
		else if (clkEn)
			pinPrev_q <= pinIn;
	end

	////////////////////////////////////////////////////////////////////////
	// pick the edge polarity
	always_comb
	begin
		if (edgeSel[1])
			validEdge = clkEn & (pinIn ^ pinPrev_q);        // both edges
		else if (edgeSel[0])
			validEdge = clkEn & pinIn & ~pinPrev_q;         // rising
		else
			validEdge = clkEn & ~pinIn & pinPrev_q;         // falling
	end

endmodule

// ===== rtl/tcc_timer.sv
// 16-bit timer channel with two capture/compare registers behind an avalon-mm slave
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_timer
(
	// clock, reset, enable
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              clkEn,
	// avalon-mm slave
	input  wire logic [15:0]       avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// trigger pins
	input  wire logic              firstTriggerPin,
	input  wire logic              secondTriggerPin,
	// timer output and interrupt
	output logic                   timerOut,
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	// every register below freezes while the clock enable is low
	// status and mask share one bit layout, one bit per event
	logic [15:0]        secondaryCc_q;   // secondary capture/compare
	logic [15:0]        primaryCc_q;     // primary capture/compare
	logic [15:0]        count_q;         // timer counter value
	tcc_pkg::tcc_mode_t mode_q;          // operating mode
	logic [1:0]         capCtl_q;        // capture select per register
	logic               outEn_q;         // square-wave output enable
	logic [7:0]         prescale_q;      // edge selects
	logic [3:0]         status_q;        // sticky events
	logic [3:0]         mask_q;          // interrupt mask, 1 masks
	logic               ack_q;           // bus answer phase
	logic [31:0]        rdData_q;        // read data register
	logic               irq_q;           // interrupt register
	logic               out_q;           // output register
	logic               cleared_q;       // counter was cleared, zero match armed
	tcc_pkg::tcc_edges_t edges;          // valid pin edges
	logic               running;         // counter advancing
	logic               priMatch;        // primary compare equal
	logic               secMatch;        // secondary compare equal
	logic               clearCount;      // counter clears this cycle
	logic               overflow;        // counter wraps this cycle
	logic               wrStrobe;        // write accepted
	logic               rdStrobe;        // read accepted
	logic [3:0]         events;          // events raised this cycle

	// zero value match happens only on 0000->0001 after a clear
	// a nonzero value matches on plain equality with the count
	// the arm flag keeps a freshly started counter from matching
	function automatic logic cmpHit(input logic [15:0] cmpVal, input logic [15:0] cnt, input logic armed);
		logic hit;
		hit = 1'b0;
		if (cmpVal == `TCC_COUNT_ZERO)
			hit = armed && (cnt == `TCC_COUNT_ONE);
		else
			hit = (cnt == cmpVal);
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin edge detectors
	// pins are sampled as synchronous inputs, no extra stages
	// each detector flags one cycle on the selected polarity
	tcc_edge_detect uFirstEdge
	(
		.clk       (clk),
		.rst_b     (rst_b),
		.clkEn     (clkEn),
		.pinIn     (firstTriggerPin),
		.edgeSel   (prescale_q[`TCC_EDGE_FIRST_LSB +: 2]),
		.validEdge (edges.first)
	);

	tcc_edge_detect uSecondEdge
	(
		.clk       (clk),
		.rst_b     (rst_b),
		.clkEn     (clkEn),
		.pinIn     (secondTriggerPin),
		.edgeSel   (prescale_q[`TCC_EDGE_SECOND_LSB +: 2]),
		.validEdge (edges.second)
	);

	////////////////////////////////////////////////////////////////////////
	// bus strobes: one wait cycle, answer on the next edge
	// a request is taken only while no answer is pending,
	// so a held request is never taken twice
	// every access costs two cycles, back-to-back allowed
	assign wrStrobe = clkEn & avs_write & ~ack_q;
	assign rdStrobe = clkEn & avs_read & ~ack_q;

	////////////////////////////////////////////////////////////////////////
	// counter control terms
	// nonzero matches are seen in the cycle the count equals the value
	// clear-on-match needs a nonzero primary, else it never clears
	// a register set for capture is never compared
	always_comb
	begin
		running  = clkEn && (mode_q != tcc_pkg::TCC_STOP);
		// compare against the current count, not the value after this tick
		priMatch = running && !capCtl_q[`TCC_CAP_PRI_BIT]
		           && cmpHit(primaryCc_q, count_q, cleared_q);
		secMatch = running && !capCtl_q[`TCC_CAP_SEC_BIT]
		           && cmpHit(secondaryCc_q, count_q, cleared_q);
		overflow = running && (count_q == `TCC_COUNT_MAX);
		if (!running)
			clearCount = 1'b0;
		else if (mode_q == tcc_pkg::TCC_CLEAR_ON_EDGE)
			clearCount = edges.first;
		else if (mode_q == tcc_pkg::TCC_CLEAR_ON_MATCH)
			clearCount = priMatch && (primaryCc_q != `TCC_COUNT_ZERO);
		else
			clearCount = 1'b0;
		events = '0;
		events[`TCC_ST_SEC_MATCH] = secMatch;
		events[`TCC_ST_PRI_MATCH] = priMatch;
		events[`TCC_ST_OVERFLOW]  = overflow;
		events[`TCC_ST_CAPTURE]   = clkEn && (
		                            (capCtl_q[`TCC_CAP_SEC_BIT] && edges.first) ||
		                            (capCtl_q[`TCC_CAP_PRI_BIT] && edges.second));
	end

	////////////////////////////////////////////////////////////////////////
	// timer counter
	// a stopped counter sits at zero so a start always begins there
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			count_q <= `TCC_RST_CC;
		else if (clkEn)
		begin
			if (mode_q == tcc_pkg::TCC_STOP)
				count_q <= `TCC_COUNT_ZERO;              // stopped counter holds zero
			else if (clearCount)
				count_q <= `TCC_COUNT_ZERO;              // edge or match clear
			else
				count_q <= count_q + `TCC_COUNT_ONE;     // wraps ffff to 0000
		end
		// clock enable low: count frozen, reads see it unchanged
	end

	////////////////////////////////////////////////////////////////////////
	// zero-compare arm: set by a clear, dropped after first step
	// stopping drops the arm, so a start gives no zero match
	// overflow arms it as well, the wrap counts as a clear
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cleared_q <= 1'b0;
		else if (clkEn)
		begin
			if (!running)
				cleared_q <= 1'b0;                       // start gives no zero match
			else if (clearCount || overflow)
				cleared_q <= 1'b1;
			else if (count_q == `TCC_COUNT_ONE)
				cleared_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// secondary register: write, or capture on first pin edge
	// a capture wins over a write in the same cycle,
	// since the captured count cannot be had again
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			secondaryCc_q <= `TCC_RST_CC;
		else if (clkEn && capCtl_q[`TCC_CAP_SEC_BIT] && edges.first)
			secondaryCc_q <= count_q;
		else if (wrStrobe && avs_address == `TCC_OFF_SECONDARY)
			secondaryCc_q <= beMerge(secondaryCc_q, avs_writedata[15:0], avs_byteenable[1:0]);
		// compare mode: triggers leave it untouched
	end

	////////////////////////////////////////////////////////////////////////
	// primary register: write, or capture on second pin edge
	// same priority as the secondary register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			primaryCc_q <= `TCC_RST_CC;
		else if (clkEn && capCtl_q[`TCC_CAP_PRI_BIT] && edges.second)
			primaryCc_q <= count_q;
		else if (wrStrobe && avs_address == `TCC_OFF_PRIMARY)
			primaryCc_q <= beMerge(primaryCc_q, avs_writedata[15:0], avs_byteenable[1:0]);
	end

	// byte-lane merge for 16-bit registers
	// upper lanes have no storage and are ignored
	function automatic logic [15:0] beMerge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
		logic [15:0] res;
		res = old;
		if (be[0])
			res[7:0] = nw[7:0];
		if (be[1])
			res[15:8] = nw[15:8];
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// control registers
	// control fields live in the low byte lane only
	// unmapped writes fall through and change nothing
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_q     <= tcc_pkg::TCC_STOP;
			capCtl_q   <= 2'h0;
			outEn_q    <= 1'b0;
			prescale_q <= 8'h00;
			mask_q     <= `TCC_RST_MASK;
		end
		else if (wrStrobe && avs_byteenable[0])
		begin
			if (avs_address == `TCC_OFF_MODE)
				mode_q <= tcc_pkg::tcc_mode_t'(avs_writedata[`TCC_MODE_LSB +: `TCC_MODE_W]);
			else if (avs_address == `TCC_OFF_CAPCTL)
				capCtl_q <= avs_writedata[1:0];
			else if (avs_address == `TCC_OFF_OUTCTL)
				outEn_q <= avs_writedata[`TCC_OUT_EN_BIT];
			else if (avs_address == `TCC_OFF_PRESCALE)
				prescale_q <= avs_writedata[7:0];
			else if (avs_address == `TCC_OFF_MASK)
				mask_q <= avs_writedata[`TCC_ST_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// square-wave output: toggles on every primary match
	// disabling the output parks it low
	// in clear-on-match mode the half period is the primary value plus one count
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			out_q <= 1'b0;
		else if (clkEn)
		begin
			if (!outEn_q)
				out_q <= 1'b0;
			else if (priMatch)
				out_q <= ~out_q;                         // period 2*(M+1) counts when clearing on match
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status: read clears, a new event wins over the clear
	// the read returns the old bits and clears them in one edge,
	// so an event landing on the read edge is kept for the next read
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			status_q <= 4'h0;
		else if (rdStrobe && avs_address == `TCC_OFF_STATUS)
			status_q <= events;
		else if (clkEn)
			status_q <= status_q | events;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt output
	// registered, so it trails the status bits by one cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			irq_q <= 1'b0;
		else if (clkEn)
			irq_q <= |(status_q & ~mask_q);
	end

	////////////////////////////////////////////////////////////////////////
	// bus answer and read data
	// ack pulses for one cycle after each taken request
	// read data is loaded on the taking edge and then holds
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ack_q    <= 1'b0;
			rdData_q <= 32'h0000_0000;
		end
		else if (clkEn)
		begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
			if (rdStrobe)
			begin
				if (avs_address == `TCC_OFF_SECONDARY)
					rdData_q <= {16'h0000, secondaryCc_q};
				else if (avs_address == `TCC_OFF_PRIMARY)
					rdData_q <= {16'h0000, primaryCc_q};
				else if (avs_address == `TCC_OFF_COUNTER)
					rdData_q <= {16'h0000, count_q};     // plain sample
				else if (avs_address == `TCC_OFF_MODE)
					rdData_q <= {30'h0000_0000, mode_q};
				else if (avs_address == `TCC_OFF_CAPCTL)
					rdData_q <= {30'h0000_0000, capCtl_q};
				else if (avs_address == `TCC_OFF_OUTCTL)
					rdData_q <= {31'h0000_0000, outEn_q};
				else if (avs_address == `TCC_OFF_PRESCALE)
					rdData_q <= {24'h00_0000, prescale_q};
				else if (avs_address == `TCC_OFF_STATUS)
					rdData_q <= {28'h000_0000, status_q};
				else if (avs_address == `TCC_OFF_MASK)
					rdData_q <= {28'h000_0000, mask_q};
				else
					rdData_q <= 32'h0000_0000;           // unmapped reads zero
			end
		end
	end

	// outputs straight from flops
	// only an inverter on waitrequest between these flops and the pins
	assign avs_readdata    = rdData_q;
	assign avs_waitrequest = ~ack_q;
	assign timerOut        = out_q;
	assign irq             = irq_q;

endmodule

// ===== verification/tcc_timer_asserts.sv
// port-level checks on the timer capture/compare block
`timescale 1ns/1ps
`include "tcc_defs.svh"

module tcc_timer_chk
(
	// clock, reset, enable
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        clkEn,
	// avalon-mm slave
	input wire logic [15:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// pins
	input wire logic        firstTriggerPin,
	input wire logic        secondTriggerPin,
	input wire logic        timerOut,
	input wire logic        irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////
	// bus answer timing
	chk_wait_take: assert property ((avs_read || avs_write) && avs_waitrequest && clkEn |=> !avs_waitrequest)
		else $error("request not answered one cycle later");
	chk_wait_one: assert property (!avs_waitrequest && clkEn |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without a request");
	// read data only move after a taken read
	chk_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data changed without a read");
	chk_unmap_zero: assert property (avs_read && avs_waitrequest && avs_address == 16'hff00 |=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_upper_zero: assert property (!avs_waitrequest && $past(avs_read) |-> avs_readdata[31:16] == 16'h0)
		else $error("upper read bits not zero");

	////////////////////////////////////////////////////////////////
	// interrupt and output quiet cases
	chk_mask_quiet: assert property (avs_write && avs_waitrequest && clkEn && avs_address == `TCC_OFF_MASK
		&& avs_writedata[3:0] == 4'hf |-> ##2 !irq)
		else $error("irq high with all sources masked");
	chk_reset_quiet: assert property ($rose(rst_b) |-> !irq && !timerOut)
		else $error("output or irq active after reset");
endmodule

bind tcc_timer tcc_timer_chk chk
(
	.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .firstTriggerPin(firstTriggerPin),
	.secondTriggerPin(secondTriggerPin), .timerOut(timerOut), .irq(irq)
);

// ===== verification/tcc_pin_model.sv
// far-side model: drives the trigger pins and times the square-wave output
`timescale 1ns/1ps

module tcc_pin_model
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// pin commands from the bench
	input  wire logic        firstReq,
	input  wire logic        secondReq,
	// pins into the block
	output logic             firstTriggerPin,
	output logic             secondTriggerPin,
	// timer output and its measured half period
	input  wire logic        timerOut,
	output logic [15:0]      halfPeriod
);
	logic [15:0] runCnt_q;  // cycles since the last output change
	logic        last_q;    // output level one cycle ago

	// pins follow the bench; it keeps square-wave primary nonzero
	assign firstTriggerPin  = firstReq;
	assign secondTriggerPin = secondReq;

	////////////////////////////////////////////////////////////////
	// time each output level in clock cycles
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			runCnt_q   <= 16'h0;
			last_q     <= 1'b0;
			halfPeriod <= 16'h0;
		end
		else if (timerOut != last_q)
		begin
			halfPeriod <= runCnt_q + 16'h1;
			runCnt_q   <= 16'h0;
			last_q     <= timerOut;
		end
		else
			runCnt_q <= runCnt_q + 16'h1;
	end
endmodule

// ===== verification/timer16_capture_compare_tb_top.sv
// self-checking bench for the timer capture/compare block
`timescale 1ns/1ps
`include "tcc_defs.svh"

module timer16_capture_compare_tb_top;
	logic        clk;             // bench clock, 40 MHz
	logic        rst_b;           // active-low reset
	logic        clkEn;           // clock enable to the block
	logic [15:0] avsAddress;      // bus address
	logic        avsRead;         // bus read
	logic        avsWrite;        // bus write
	logic [31:0] avsWritedata;    // bus write data
	logic [31:0] avsReaddata;     // bus read data
	logic        avsWaitrequest;  // bus wait
	logic        firstReq;        // pin commands to the model
	logic        secondReq;
	logic        firstPin;        // trigger pins
	logic        secondPin;
	logic        timerOut;        // square output
	logic        irq;             // interrupt
	logic [15:0] gap;             // measured half period
	int          failures;        // mismatches
	int          samples_checked; // comparisons made
	int          cycles;          // timeout counter
	logic [31:0] q;               // last read value
	logic [31:0] c;               // reference count
	logic [15:0] v;               // random setting

	// clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	tcc_timer dut
	(
		.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .avs_address(avsAddress), .avs_read(avsRead),
		.avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hf),
		.avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .firstTriggerPin(firstPin),
		.secondTriggerPin(secondPin), .timerOut(timerOut), .irq(irq)
	);

	tcc_pin_model pins
	(
		.clk(clk), .rst_b(rst_b), .firstReq(firstReq), .secondReq(secondReq), .firstTriggerPin(firstPin),
		.secondTriggerPin(secondPin), .timerOut(timerOut), .halfPeriod(gap)
	);

	////////////////////////////////////////////////////////////////
	// one avalon transfer, held until waitrequest is sampled low
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
		avsAddress   <= a;
		avsWritedata <= d;
		avsWrite     <= wr;
		avsRead      <= !wr;
		@(posedge clk);
		// waitrequest low ends this wait, the hang guard only if it never drops
		while (avsWaitrequest !== 1'b0)
			@(posedge clk);
		q = avsReaddata;
		avsWrite <= 1'b0;
		avsRead  <= 1'b0;
		@(posedge clk);
	endtask

	// count and report one comparison
	task automatic check(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	// verdict and end of run
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			failures++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		{rst_b, avsAddress, avsRead, avsWrite, avsWritedata, firstReq, secondReq} = '0;
		{failures, samples_checked, cycles} = '0;
		clkEn = 1'b1;
		v = 16'($urandom(32'h7cf0));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// reset values and an unmapped place
		xfer(1'b0, `TCC_OFF_SECONDARY, 32'h0);
		check(q === 32'h0, "secondary reset value");
		xfer(1'b0, `TCC_OFF_MASK, 32'h0);
		check(q[3:0] === `TCC_RST_MASK, "mask reset value");
		xfer(1'b0, 16'hff00, 32'h0);
		check(q === 32'h0, "unmapped read");
		$display("test reset done");
		// free run, zero compare, counter read, overflow and irq
		xfer(1'b1, `TCC_OFF_MODE, 32'h2);
		xfer(1'b0, `TCC_OFF_COUNTER, 32'h0);
		c = q;
		xfer(1'b0, `TCC_OFF_COUNTER, 32'h0);
		check(q === c + 32'h3, "counter step");
		// frozen cycles must not advance the count
		c = q;
		clkEn <= 1'b0;
		repeat ($urandom_range(9, 2)) @(posedge clk);
		clkEn <= 1'b1;
		xfer(1'b0, `TCC_OFF_COUNTER, 32'h0);
		check(q === c + 32'h3, "counter frozen while disabled");
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		check(q[0] === 1'b0, "zero compare at start");
		xfer(1'b1, `TCC_OFF_MASK, 32'hb);
		while (irq !== 1'b1 && cycles < 90000)
			@(posedge clk);
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		check(q[2] === 1'b1 && q[0] === 1'b1, "overflow and zero match");
		check(irq === 1'b0, "irq after status read");
		$display("test free run done");
		// compare mode ignores a capture edge
		v = 16'($urandom_range(200, 16));
		xfer(1'b1, `TCC_OFF_MODE, 32'h0);
		xfer(1'b1, `TCC_OFF_SECONDARY, {16'h0, v});
		xfer(1'b1, `TCC_OFF_PRESCALE, 32'h10);
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		xfer(1'b1, `TCC_OFF_MODE, 32'h2);
		firstReq <= 1'b1;
		repeat (3) @(posedge clk);
		firstReq <= 1'b0;
		repeat (v + 20) @(posedge clk);
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		check(q[0] === 1'b1, "secondary match");
		xfer(1'b0, `TCC_OFF_SECONDARY, 32'h0);
		check(q === {16'h0, v}, "compare value kept");
		$display("test compare done");
		// dual capture on both pins at once
		xfer(1'b1, `TCC_OFF_CAPCTL, 32'h3);
		xfer(1'b1, `TCC_OFF_PRESCALE, 32'h50);
		repeat ($urandom_range(30, 5)) @(posedge clk);
		xfer(1'b0, `TCC_OFF_COUNTER, 32'h0);
		c = q;
		firstReq  <= 1'b1;
		secondReq <= 1'b1;
		@(posedge clk);
		xfer(1'b0, `TCC_OFF_SECONDARY, 32'h0);
		check(q >= c + 32'h3 && q <= c + 32'h4, "first pin capture");
		v = q[15:0];
		xfer(1'b0, `TCC_OFF_PRIMARY, 32'h0);
		check(q === {16'h0, v}, "second pin capture");
		firstReq  <= 1'b0;
		secondReq <= 1'b0;
		$display("test capture done");
		// square wave with secondary match masked
		v = 16'($urandom_range(20, 3));
		xfer(1'b1, `TCC_OFF_MODE, 32'h0);
		xfer(1'b1, `TCC_OFF_CAPCTL, 32'h0);
		xfer(1'b1, `TCC_OFF_PRIMARY, {16'h0, v});
		xfer(1'b1, `TCC_OFF_SECONDARY, 32'h1);
		xfer(1'b1, `TCC_OFF_OUTCTL, 32'h1);
		xfer(1'b1, `TCC_OFF_MASK, 32'hf);
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		xfer(1'b1, `TCC_OFF_MODE, 32'h3);
		repeat (8 * (v + 1)) @(posedge clk);
		check(gap === v + 16'h1, "square half period");
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		check(q[0] === 1'b1 && irq === 1'b0, "masked secondary match");
		$display("test square done");
		// clear on first pin edge with a zero secondary compare
		xfer(1'b1, `TCC_OFF_MODE, 32'h0);
		xfer(1'b1, `TCC_OFF_SECONDARY, 32'h0);
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		xfer(1'b1, `TCC_OFF_MODE, 32'h1);
		repeat ($urandom_range(40, 10)) @(posedge clk);
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		check(q[0] === 1'b0, "no zero match after start");
		firstReq <= 1'b1;
		@(posedge clk);
		xfer(1'b0, `TCC_OFF_COUNTER, 32'h0);
		check(q === 32'h0, "clear on first pin edge");
		firstReq <= 1'b0;
		xfer(1'b0, `TCC_OFF_STATUS, 32'h0);
		check(q[0] === 1'b1, "zero match after pin clear");
		$display("test edge clear done");
		end_sim();
	end
endmodule
